// ==== include/usa_map.svh ====
// Register offsets, field positions and reset values of the address control block
`ifndef USA_MAP_SVH
`define USA_MAP_SVH
`define USA_OFS_MODE        8'h00
`define USA_OFS_INT_STATUS  8'h04
`define USA_OFS_INT_ENABLE  8'h08
`define USA_OFS_INT_CLEAR   8'h0C
`define USA_OFS_SETUP_FIRST 8'h10
`define USA_OFS_SETUP_SECND 8'h14
`define USA_OFS_SETUP_ADDR  8'h18
`define USA_OFS_USB_ADDRESS 8'h1C
`define USA_OFS_SETUP_CTRL  8'h20
`define USA_OFS_EP_CONTROL  8'h24
`define USA_OFS_EP_IN_CTRL  8'h28
`define USA_BIT_AUTO_DIS    0
`define USA_BIT_SETUP_RCVD  0
`define USA_BIT_ADDR_DONE   1
`define USA_BIT_LOAD_REQ    7
`define USA_BIT_PROTECT     0
`define USA_BIT_DIRECTION   0
`define USA_BIT_FORCE_NAK   7
`define USA_BIT_SHORT_EN    6
`define USA_NUM_EVENTS      2
`define USA_RST_IN_CTRL     8'h80
`define USA_REQ_SET_ADDRESS 8'h05
`define USA_REQ_TYPE_STD    8'h00
`endif

// ==== include/usa_pkg.sv ====
// Types shared by the address control block
`default_nettype none
package usa_pkg;
	// Fields of a received setup packet that the block keeps
	typedef struct packed {
		logic [7:0] req_type;   // First setup byte
		logic [7:0] req_code;   // Second setup byte
		logic [7:0] addr_value; // Low byte of the value field
	} usa_setup_t;
	// Answer given to an IN token on the control endpoint
	typedef enum logic [1:0] {
		USA_REPLY_NONE,
		USA_REPLY_NAK,
		USA_REPLY_ZLP
	} usa_reply_t;
endpackage : usa_pkg
`default_nettype wire

// ==== src/usa_ep0_status.sv ====
// Status stage responder for IN tokens on the control endpoint
`default_nettype none
module usa_ep0_status (
	input  wire logic              i_core_clk,    // Core clock
	input  wire logic              i_reset,       // Synchronous reset, high
	input  wire logic              i_in_token,    // IN token pulse on endpoint zero
	input  wire logic              i_in_ack,      // Host ACK pulse after our packet
	input  wire logic              i_protect,     // Endpoint protect bit
	input  wire logic              i_dir_in,      // Endpoint direction is IN
	input  wire logic              i_force_nak,   // Force NAK reply
	input  wire logic              i_short_en,    // Short packet enable
	input  wire logic              i_auto_status, // Hardware-owned status stage
	output usa_pkg::usa_reply_t    o_reply,       // Reply, one cycle after token
	output logic                   o_status_done  // Status stage finished pulse
);
	usa_pkg::usa_reply_t reply_r;
	usa_pkg::usa_reply_t reply_nxt;
	logic                sent_r;
	logic                sent_nxt;
	logic                done_r;
	logic                done_nxt;
	logic                fw_ready;

	// Firmware has armed a zero-length IN reply
	assign fw_ready = !i_protect && i_dir_in && !i_force_nak && i_short_en;

	// Reply choice and tracking of the sent packet until its ACK
	always_comb begin
		reply_nxt = usa_pkg::USA_REPLY_NONE;
		sent_nxt  = sent_r;
		done_nxt  = 1'b0;
		if (i_in_token) begin
			if (fw_ready || i_auto_status) begin
				reply_nxt = usa_pkg::USA_REPLY_ZLP;
				sent_nxt  = 1'b1;
			end else begin
				reply_nxt = usa_pkg::USA_REPLY_NAK;
				sent_nxt  = 1'b0;
			end
		end else if (i_in_ack && sent_r) begin
			done_nxt = 1'b1;
			sent_nxt = 1'b0;
		end
	end

	// Responder state
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			reply_r <= usa_pkg::USA_REPLY_NONE;
			sent_r  <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			reply_r <= reply_nxt;
			sent_r  <= sent_nxt;
			done_r  <= done_nxt;
		end
	end

	assign o_reply       = reply_r;
	assign o_status_done = done_r;

	sequence s_armed_token;
		i_in_token && fw_ready;
	endsequence
	property p_zlp_reply;
		@(posedge i_core_clk) disable iff (i_reset)
		s_armed_token |=> (o_reply == usa_pkg::USA_REPLY_ZLP);
	endproperty
	a_zlp_reply: assert property (p_zlp_reply) else $error("No zero-length reply");

	property p_nak_protect;
		@(posedge i_core_clk) disable iff (i_reset)
		(i_in_token && i_protect && !i_auto_status) |=> (o_reply == usa_pkg::USA_REPLY_NAK);
	endproperty
	a_nak_protect: assert property (p_nak_protect) else $error("Protected endpoint answered");

	property p_done_after_zlp;
		@(posedge i_core_clk) disable iff (i_reset)
		o_status_done |-> $past(i_in_ack) && $past(sent_r);
	endproperty
	a_done_after_zlp: assert property (p_done_after_zlp) else $error("Done without packet");
endmodule // usa_ep0_status
`default_nettype wire

// ==== src/usa_irq_bits.sv ====
// Sticky event status bits with enable gating onto one interrupt level
`default_nettype none
module usa_irq_bits #(
	parameter int N = 2
) (
	input  wire logic         i_core_clk, // Core clock
	input  wire logic         i_reset,    // Synchronous reset, high
	input  wire logic [N-1:0] i_set,      // Event pulses
	input  wire logic [N-1:0] i_clr,      // Clear pulses from software
	input  wire logic [N-1:0] i_enable,   // Enable mask
	output logic      [N-1:0] o_status,   // Sticky status
	output logic              o_irq       // Interrupt level
);
	logic [N-1:0] status_r;
	logic [N-1:0] status_nxt;

	// Set wins over a clear in the same cycle
	always_comb begin
		status_nxt = (status_r & ~i_clr) | i_set;
	end

	// Status register
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end

	assign o_status = status_r;
	assign o_irq    = |(status_r & i_enable);

	property p_set_wins;
		@(posedge i_core_clk) disable iff (i_reset)
		(i_set != '0) |=> ((status_r & $past(i_set)) == $past(i_set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Event lost on clear");
endmodule // usa_irq_bits
`default_nettype wire

// ==== src/usa_set_address.sv ====
// Address assignment control for the control endpoint, with Avalon-MM registers
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`include "usa_map.svh"
`default_nettype none
// Overview of operation
// - Disabled mode: every setup packet raises setup flag
// - Armed address loads after status stage
// - Armed endpoint answers IN with ZLP
// - Status IN raises address done flag
// - Auto mode suppresses flag for set-address request, handles it
module usa_set_address (
	input  wire logic                i_core_clk,        // Core clock, 250 MHz
	input  wire logic                i_reset,           // Synchronous reset, high
	input  wire logic [7:0]          i_avs_address,     // Byte address
	input  wire logic                i_avs_read,        // Read request
	input  wire logic                i_avs_write,       // Write request
	input  wire logic [31:0]         i_avs_writedata,   // Write data
	input  wire logic [3:0]          i_avs_byteenable,  // Byte enables
	output logic      [31:0]         o_avs_readdata,    // Read data
	output logic                     o_avs_waitrequest, // Wait request
	input  wire logic                i_setup_valid,     // Setup packet received pulse
	input  wire usa_pkg::usa_setup_t i_setup,           // Setup fields with the pulse
	input  wire logic                i_in_token,        // IN token on endpoint zero
	input  wire logic                i_in_ack,          // Host ACK of our IN packet
	output usa_pkg::usa_reply_t      o_in_reply,        // Reply to the IN token
	output logic      [6:0]          o_dev_addr,        // Current device address
	output logic                     o_irq              // Interrupt level
);
	logic                  ack_r;
	logic                  ack_nxt;
	logic [31:0]           rdata_r;
	logic [31:0]           rdata_nxt;
	logic                  auto_dis_r;
	logic                  auto_dis_nxt;
	logic [1:0]            int_en_r;
	logic [1:0]            int_en_nxt;
	usa_pkg::usa_setup_t   setup_r;
	usa_pkg::usa_setup_t   setup_nxt;
	logic                  load_req_r;
	logic                  load_req_nxt;
	logic [6:0]            addr_r;
	logic [6:0]            addr_nxt;
	logic                  protect_r;
	logic                  protect_nxt;
	logic                  dir_in_r;
	logic                  dir_in_nxt;
	logic [7:0]            in_ctrl_r;
	logic [7:0]            in_ctrl_nxt;
	logic                  auto_stat_r;
	logic                  auto_stat_nxt;
	logic                  req;
	logic                  wr_take;
	logic                  is_set_addr;
	logic                  auto_handle;
	logic                  status_done;
	logic [1:0]            int_set;
	logic [1:0]            int_clr;
	logic [1:0]            int_status;

	// Single wait state: every request is answered on the second cycle
	assign req               = i_avs_read || i_avs_write;
	assign o_avs_waitrequest = req && !ack_r;
	assign wr_take           = i_avs_write && ack_r && i_avs_byteenable[0];
	assign o_avs_readdata    = rdata_r;

	// Standard request assigning the address
	assign is_set_addr = (i_setup.req_type == `USA_REQ_TYPE_STD)
		&& (i_setup.req_code == `USA_REQ_SET_ADDRESS);
	// Auto mode takes the request over entirely
	assign auto_handle = i_setup_valid && is_set_addr && !auto_dis_r;

	// Event sources and software clears
	always_comb begin
		int_set = '0;
		int_set[`USA_BIT_SETUP_RCVD] = i_setup_valid && !auto_handle;
		int_set[`USA_BIT_ADDR_DONE]  = status_done;
		int_clr = '0;
		if (wr_take && (i_avs_address == `USA_OFS_INT_CLEAR)) begin
			int_clr = i_avs_writedata[1:0];
		end
	end

	// Bus handshake and read data capture
	always_comb begin
		ack_nxt   = req && !ack_r;
		rdata_nxt = rdata_r;
		if (req && !ack_r) begin
			rdata_nxt = '0;
			if (!i_avs_read) begin
				rdata_nxt = '0;
			end else if (i_avs_address == `USA_OFS_MODE) begin
				rdata_nxt[`USA_BIT_AUTO_DIS] = auto_dis_r;
			end else if (i_avs_address == `USA_OFS_INT_STATUS) begin
				rdata_nxt[1:0] = int_status;
			end else if (i_avs_address == `USA_OFS_INT_ENABLE) begin
				rdata_nxt[1:0] = int_en_r;
			end else if (i_avs_address == `USA_OFS_SETUP_FIRST) begin
				rdata_nxt[7:0] = setup_r.req_type;
			end else if (i_avs_address == `USA_OFS_SETUP_SECND) begin
				rdata_nxt[7:0] = setup_r.req_code;
			end else if (i_avs_address == `USA_OFS_SETUP_ADDR) begin
				rdata_nxt[7:0] = setup_r.addr_value;
			end else if (i_avs_address == `USA_OFS_USB_ADDRESS) begin
				rdata_nxt[7:0] = {load_req_r, addr_r};
			end else if (i_avs_address == `USA_OFS_SETUP_CTRL) begin
				rdata_nxt[`USA_BIT_PROTECT] = protect_r;
			end else if (i_avs_address == `USA_OFS_EP_CONTROL) begin
				rdata_nxt[`USA_BIT_DIRECTION] = dir_in_r;
			end else if (i_avs_address == `USA_OFS_EP_IN_CTRL) begin
				rdata_nxt[7:0] = in_ctrl_r;
			end
		end
	end

	// Software writes and hardware updates of the control state
	always_comb begin
		auto_dis_nxt  = auto_dis_r;
		int_en_nxt    = int_en_r;
		setup_nxt     = setup_r;
		load_req_nxt  = load_req_r;
		addr_nxt      = addr_r;
		protect_nxt   = protect_r;
		dir_in_nxt    = dir_in_r;
		in_ctrl_nxt   = in_ctrl_r;
		auto_stat_nxt = auto_stat_r;
		if (wr_take) begin
			if (i_avs_address == `USA_OFS_MODE) begin
				auto_dis_nxt = i_avs_writedata[`USA_BIT_AUTO_DIS];
			end else if (i_avs_address == `USA_OFS_INT_ENABLE) begin
				int_en_nxt = i_avs_writedata[1:0];
			end else if (i_avs_address == `USA_OFS_USB_ADDRESS) begin
				load_req_nxt = i_avs_writedata[`USA_BIT_LOAD_REQ];
			end else if (i_avs_address == `USA_OFS_SETUP_CTRL) begin
				protect_nxt = i_avs_writedata[`USA_BIT_PROTECT];
			end else if (i_avs_address == `USA_OFS_EP_CONTROL) begin
				dir_in_nxt = i_avs_writedata[`USA_BIT_DIRECTION];
			end else if (i_avs_address == `USA_OFS_EP_IN_CTRL) begin
				in_ctrl_nxt = i_avs_writedata[7:0];
			end
		end
		// Completed status stage loads the armed address, then disarms
		if (status_done) begin
			auto_stat_nxt = 1'b0;
			if (load_req_r) begin
				addr_nxt     = setup_r.addr_value[6:0];
				load_req_nxt = 1'b0;
			end
		end
		// A new setup packet always locks the endpoint until firmware releases it; auto mode also arms the load and the status stage
		if (i_setup_valid) begin
			setup_nxt   = i_setup;
			protect_nxt = 1'b1;
			auto_stat_nxt = 1'b0;
			if (auto_handle) begin
				load_req_nxt  = 1'b1;
				auto_stat_nxt = 1'b1;
			end
		end
	end

	// Register stage
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ack_r       <= 1'b0;
			rdata_r     <= '0;
			auto_dis_r  <= 1'b0;
			int_en_r    <= '0;
			setup_r     <= '0;
			load_req_r  <= 1'b0;
			addr_r      <= '0;
			protect_r   <= 1'b1;
			dir_in_r    <= 1'b0;
			in_ctrl_r   <= `USA_RST_IN_CTRL;
			auto_stat_r <= 1'b0;
		end else begin
			ack_r       <= ack_nxt;
			rdata_r     <= rdata_nxt;
			auto_dis_r  <= auto_dis_nxt;
			int_en_r    <= int_en_nxt;
			setup_r     <= setup_nxt;
			load_req_r  <= load_req_nxt;
			addr_r      <= addr_nxt;
			protect_r   <= protect_nxt;
			dir_in_r    <= dir_in_nxt;
			in_ctrl_r   <= in_ctrl_nxt;
			auto_stat_r <= auto_stat_nxt;
		end
	end

	assign o_dev_addr = addr_r;

	// Sticky event flags and interrupt
	usa_irq_bits #(
		.N(`USA_NUM_EVENTS)
	) u_irq (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_set      (int_set),
		.i_clr      (int_clr),
		.i_enable   (int_en_r),
		.o_status   (int_status),
		.o_irq      (o_irq)
	);

	// Status stage responder
	usa_ep0_status u_status (
		.i_core_clk    (i_core_clk),
		.i_reset       (i_reset),
		.i_in_token    (i_in_token),
		.i_in_ack      (i_in_ack),
		.i_protect     (protect_r),
		.i_dir_in      (dir_in_r),
		.i_force_nak   (in_ctrl_r[`USA_BIT_FORCE_NAK]),
		.i_short_en    (in_ctrl_r[`USA_BIT_SHORT_EN]),
		.i_auto_status (auto_stat_r),
		.o_reply       (o_in_reply),
		.o_status_done (status_done)
	);

	property p_setup_flag;
		@(posedge i_core_clk) disable iff (i_reset)
		(i_setup_valid && auto_dis_r) |=> int_status[`USA_BIT_SETUP_RCVD];
	endproperty
	a_setup_flag: assert property (p_setup_flag) else $error("Setup flag not raised");

	property p_auto_suppress;
		@(posedge i_core_clk) disable iff (i_reset)
		(auto_handle && !int_status[`USA_BIT_SETUP_RCVD])
			|=> !int_status[`USA_BIT_SETUP_RCVD] && load_req_r;
	endproperty
	a_auto_suppress: assert property (p_auto_suppress) else $error("Auto request leaked");

	property p_addr_load;
		@(posedge i_core_clk) disable iff (i_reset)
		(status_done && load_req_r && !i_setup_valid)
			|=> (o_dev_addr == $past(setup_r.addr_value[6:0])) && !load_req_r;
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("Address not loaded");

	property p_addr_hold;
		@(posedge i_core_clk) disable iff (i_reset)
		!(status_done && load_req_r) |=> $stable(o_dev_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("Address changed early");

	property p_done_flag;
		@(posedge i_core_clk) disable iff (i_reset)
		status_done |=> int_status[`USA_BIT_ADDR_DONE];
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("Done flag not raised");

	sequence s_bus_req;
		req && !ack_r;
	endsequence
	property p_bus_answer;
		@(posedge i_core_clk) disable iff (i_reset)
		s_bus_req |-> o_avs_waitrequest ##1 (!o_avs_waitrequest || !req);
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("Bus answer late");
endmodule // usa_set_address
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the address control block
`include "usa_map.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic                clk;
	logic                rst;
	logic [7:0]          av_addr;
	logic                av_rd;
	logic                av_wr;
	logic [31:0]         av_wdata;
	logic [3:0]          av_be;
	logic [31:0]         av_rdata;
	logic                av_wait;
	logic                stp_vld;
	usa_pkg::usa_setup_t stp;
	logic                tok;
	logic                ack;
	usa_pkg::usa_reply_t reply;
	logic [6:0]          dev_addr;
	logic                irq;
	int                  bad_count;
	int                  checks;
	logic [7:0]          rst_ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h30};
	logic [7:0]          rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h80, 8'h00};

	// Device under test and host model
	usa_set_address u_dut (
		.i_core_clk(clk), .i_reset(rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
		.i_avs_write(av_wr), .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be),
		.o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_setup_valid(stp_vld),
		.i_setup(stp), .i_in_token(tok), .i_in_ack(ack), .o_in_reply(reply),
		.o_dev_addr(dev_addr), .o_irq(irq));
	usa_host_model host (
		.i_core_clk(clk), .i_in_reply(reply), .o_setup_valid(stp_vld), .o_setup(stp),
		.o_in_token(tok), .o_in_ack(ack));

	// Clock, 4 ns period
	always #2 clk = ~clk;

	// Verdict and end of run
	task automatic print_verdict();
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Compare a register or pin value
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Compare a reply to an IN token
	task automatic chk_rep(input usa_pkg::usa_reply_t got, input usa_pkg::usa_reply_t exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon transfer, held until the rising edge that samples waitrequest low;
	// read data is taken and the request released at that same edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		av_rd    <= !w;
		av_wr    <= w;
		av_addr  <= a;
		av_wdata <= d;
		@(posedge clk);
		while (av_wait !== 1'b0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (av_wait !== 1'b0) begin
			bad_count++;
			print_verdict();
		end
		q = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask

	// Register write and checked register read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk_reg(q, e);
	endtask

	// Expected reply and status word
	function automatic usa_pkg::usa_reply_t exp_reply(input logic armed);
		return armed ? usa_pkg::USA_REPLY_ZLP : usa_pkg::USA_REPLY_NAK;
	endfunction
	function automatic logic [31:0] exp_stat(input logic done, input logic rcvd);
		return {30'h0, done, rcvd};
	endfunction

	// Main sequence
	initial begin
		logic [7:0]          a;
		logic [6:0]          cur;
		usa_pkg::usa_reply_t r;
		clk = 1'b0;
		rst = 1'b1;
		av_addr = 8'h00;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wdata = 32'h0000_0000;
		av_be = 4'hF;
		bad_count = 0;
		checks = 0;
		cur = 7'h00;
		void'($urandom(51554));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (rst_ofs[i]) rd_chk(rst_ofs[i], {24'h00_0000, rst_val[i]});
		// Automatic mode: request handled with no setup flag
		a = 8'($urandom_range(127, 1));
		host.send_setup(`USA_REQ_TYPE_STD, `USA_REQ_SET_ADDRESS, a);
		rd_chk(`USA_OFS_INT_STATUS, exp_stat(1'b0, 1'b0));
		host.status_in(r, 1);
		chk_rep(r, exp_reply(1'b1));
		repeat (3) @(posedge clk);
		cur = a[6:0];
		chk_reg({25'h0, dev_addr}, {25'h0, cur});
		rd_chk(`USA_OFS_INT_STATUS, exp_stat(1'b1, 1'b0));
		wr(`USA_OFS_INT_CLEAR, 32'h0000_0003);
		host.send_setup(8'h80, 8'h06, 8'h00);
		rd_chk(`USA_OFS_INT_STATUS, exp_stat(1'b0, 1'b1));
		wr(`USA_OFS_INT_CLEAR, 32'h0000_0003);
		// Disabled mode: firmware-driven address assignment
		wr(`USA_OFS_MODE, 32'h0000_0001);
		wr(`USA_OFS_INT_ENABLE, 32'h0000_0003);
		for (int i = 0; i < 4; i++) begin
			a = {1'b0, 7'(cur + 7'($urandom_range(126, 1)))};
			host.send_setup(`USA_REQ_TYPE_STD, `USA_REQ_SET_ADDRESS, a);
			rd_chk(`USA_OFS_INT_STATUS, exp_stat(1'b0, 1'b1));
			chk_reg({31'h0, irq}, 32'h0000_0001);
			rd_chk(`USA_OFS_SETUP_FIRST, {24'h00_0000, `USA_REQ_TYPE_STD});
			rd_chk(`USA_OFS_SETUP_SECND, {24'h00_0000, `USA_REQ_SET_ADDRESS});
			rd_chk(`USA_OFS_SETUP_ADDR, {24'h00_0000, a});
			host.status_in(r, 0);
			chk_rep(r, exp_reply(1'b0));
			wr(`USA_OFS_USB_ADDRESS, 32'h0000_0080);
			wr(`USA_OFS_SETUP_CTRL, 32'h0000_0000);
			wr(`USA_OFS_EP_CONTROL, 32'h0000_0001);
			wr(`USA_OFS_EP_IN_CTRL, 32'h0000_0040);
			host.status_in(r, $urandom_range(3, 0));
			chk_rep(r, exp_reply(1'b1));
			chk_reg({25'h0, dev_addr}, {25'h0, cur});
			repeat (3) @(posedge clk);
			cur = a[6:0];
			chk_reg({25'h0, dev_addr}, {25'h0, cur});
			rd_chk(`USA_OFS_INT_STATUS, exp_stat(1'b1, 1'b1));
			rd_chk(`USA_OFS_USB_ADDRESS, {25'h0, cur});
			wr(`USA_OFS_INT_CLEAR, 32'h0000_0003);
			@(negedge clk);
			chk_reg({31'h0, irq}, 32'h0000_0000);
		end
		// Masked interrupt, forced NAK, then a later transfer keeps the address
		wr(`USA_OFS_INT_ENABLE, 32'h0000_0000);
		host.send_setup(8'h80, 8'h06, 8'h33);
		@(negedge clk);
		chk_reg({31'h0, irq}, 32'h0000_0000);
		wr(`USA_OFS_SETUP_CTRL, 32'h0000_0000);
		wr(`USA_OFS_EP_IN_CTRL, 32'h0000_00C0);
		host.status_in(r, 2);
		chk_rep(r, exp_reply(1'b0));
		wr(`USA_OFS_EP_IN_CTRL, 32'h0000_0040);
		host.status_in(r, 0);
		chk_rep(r, exp_reply(1'b1));
		repeat (3) @(posedge clk);
		chk_reg({25'h0, dev_addr}, {25'h0, cur});
		print_verdict();
	end
endmodule // testbench
`default_nettype wire

// ==== tb/usa_host_model.sv ====
// Host side model issuing setup packets and IN status stages on endpoint zero
`default_nettype none
module usa_host_model (
	input  wire logic                i_core_clk,    // Core clock
	input  wire usa_pkg::usa_reply_t i_in_reply,    // Device reply to IN
	output logic                     o_setup_valid, // Setup pulse
	output usa_pkg::usa_setup_t      o_setup,       // Setup fields
	output logic                     o_in_token,    // IN token pulse
	output logic                     o_in_ack       // ACK pulse
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle lines at time zero
	initial begin
		o_setup_valid = 1'b0;
		o_setup       = '0;
		o_in_token    = 1'b0;
		o_in_ack      = 1'b0;
	end

	// One setup packet; the fields are scrambled once the pulse is over
	task automatic send_setup(input logic [7:0] t, input logic [7:0] c, input logic [7:0] a);
		@(posedge i_core_clk);
		o_setup_valid <= 1'b1;
		o_setup       <= {t, c, a};
		@(posedge i_core_clk);
		o_setup_valid <= 1'b0;
		o_setup       <= ~{t, c, a};
	endtask

	// Status stage after gap idle cycles; the reply is taken at the edge that ends
	// its single cycle, and the ACK follows only a zero-length packet
	task automatic status_in(output usa_pkg::usa_reply_t r, input int gap);
		repeat (gap) @(posedge i_core_clk);
		@(posedge i_core_clk);
		o_in_token <= 1'b1;
		@(posedge i_core_clk);
		o_in_token <= 1'b0;
		@(posedge i_core_clk);
		r = i_in_reply;
		if (r == usa_pkg::USA_REPLY_ZLP) begin
			o_in_ack <= 1'b1;
			@(posedge i_core_clk);
			o_in_ack <= 1'b0;
		end
	endtask
endmodule // usa_host_model
`default_nettype wire
